// ===== shared/boot_cfg_pkg.sv
// shared constants and types for the boot-configuration register command block
package boot_cfg_pkg;

    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          WRITE_TIME_NS    = 5000;
    localparam int          WRITE_CYCLES     = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0]  OP_BOOT_REG_READ  = 8'h14;
    localparam logic [7:0]  OP_BOOT_REG_WRITE = 8'h15;
    localparam logic [7:0]  OP_WRITE_UNLOCK   = 8'h06;
    localparam logic [7:0]  OP_STATUS_READ    = 8'h05;

    localparam int          STAT_WIP_BIT     = 0;
    localparam int          STAT_WEL_BIT     = 1;
    localparam int          STAT_QE_BIT      = 6;

    localparam int          BOOT_EN_BIT      = 0;
    localparam int          BOOT_DLY_LSB     = 1;
    localparam int          BOOT_DLY_W       = 4;
    localparam int          BOOT_ADDR_LSB    = 5;
    localparam int          BOOT_ADDR_W      = 27;
    localparam logic [31:0] BOOT_REG_RESET   = 32'h0000_0000;

    localparam logic [3:0]  REG_CTRL         = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h4;
    localparam logic [3:0]  REG_BOOT         = 4'h8;
    localparam int          CTRL_QUAD_BIT    = 0;
    localparam int          CTRL_QE_BIT      = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h0;

    localparam logic [5:0]  DATA_BITS        = 6'h20;
    localparam logic [5:0]  OPCODE_BITS      = 6'h08;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_OPCODE  = 6'h02,
        ST_RD_BOOT = 6'h04,
        ST_RD_STAT = 6'h08,
        ST_WR_DATA = 6'h10,
        ST_IGNORE  = 6'h20
    } frame_state_e;

endpackage : boot_cfg_pkg

// ===== rtl/pin_sync.sv
// two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync
#(
    parameter int         WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    initial
    begin
        if (WIDTH < 1)
            $error("pin_sync needs WIDTH of at least one");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_r;
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                begin
                    meta_r <= RESET_VAL[i];
                    q[i]   <= RESET_VAL[i];
                end
                else
                begin
                    meta_r <= d[i];
                    q[i]   <= meta_r;
                end
            end
        end
    endgenerate

endmodule : pin_sync

// ===== rtl/boot_config_register_access.sv
// serial command front end for the boot-configuration register
`timescale 1ns/10ps
// Notes on behaviour
// - boot read sends low byte first, MSB first
// - reads keep repeating every 32 bits
// - write accepted only with write latch set
// - commit only on exactly 32 bits, else discard
// - internal write starts at chip enable rise
// - status reads still served while busy
// - busy flag high through write, then low
// - write latch cleared when write finishes
// - register keeps address, delay, enable fields
// - start delay is a four-bit count
// - boot read armed only when enable set
// - quad enable picks quad boot read
module boot_config_register_access
    import boot_cfg_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        SPI_CE_N,
    input  wire logic        SPI_SCK,
    input  wire logic [3:0]  SPI_IO_IN,
    output logic      [3:0]  SPI_IO_OUT,
    output logic      [3:0]  SPI_IO_OE_N,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    output logic [BOOT_ADDR_W-1:0] BOOT_START_ADDR,
    output logic [BOOT_DLY_W-1:0]  BOOT_START_DELAY,
    output logic             BOOT_ENABLE,
    output logic             BOOT_READ_ARMED,
    output logic             BOOT_QUAD_SELECT,
    output logic             WRITE_BUSY
);

    initial
    begin
        // busy must stand at least eight cycles for the hold check; timer is 20 bits wide
        if (WRITE_CYCLES_P < 8 || WRITE_CYCLES_P > 1048575)
            $error("WRITE_CYCLES_P out of range");
    end

    logic [5:0]      sync_q;
    logic            ce_s;
    logic            sck_s;
    logic [3:0]      io_s;
    logic            ce_d_r;
    logic            sck_d_r;
    logic            ce_rise;
    logic            sck_rise;
    logic            sck_fall;

    frame_state_e    state_r;
    logic [5:0]      cnt_r;
    logic [5:0]      cnt_nxt;
    logic [5:0]      lane;
    logic            quad_r;
    logic [31:0]     rx_r;
    logic [31:0]     rx_nxt;
    logic            unlock_seen_r;

    logic            wel_r;
    logic            wip_r;
    logic [19:0]     timer_r;
    logic [31:0]     pend_r;
    logic [31:0]     boot_reg_r = BOOT_REG_RESET;
    logic [1:0]      ctrl_r;
    logic [7:0]      status;
    logic [31:0]     rd_word;
    logic [4:0]      bit_pos;
    logic            rst_done_r;

    function automatic logic [31:0] byte_swap(input logic [31:0] w);
        byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : byte_swap

    pin_sync #(
        .WIDTH     (6),
        .RESET_VAL (6'h20)
    ) u_sync (
        .clk     (CLK),
        .reset_n (RESET_N),
        .d       ({SPI_CE_N, SPI_SCK, SPI_IO_IN}),
        .q       (sync_q)
    );

    assign ce_s     = sync_q[5];
    assign sck_s    = sync_q[4];
    assign io_s     = sync_q[3:0];
    assign ce_rise  = ce_s & ~ce_d_r;
    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            ce_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
        end
        else
        begin
            ce_d_r  <= ce_s;
            sck_d_r <= sck_s;
        end
    end

    always_comb
    begin
        lane    = quad_r ? 6'd4 : 6'd1;
        cnt_nxt = cnt_r + lane;
        rx_nxt  = quad_r ? {rx_r[27:0], io_s} : {rx_r[30:0], io_s[0]};
        status  = 8'h00;
        status[STAT_WIP_BIT] = wip_r;
        status[STAT_WEL_BIT] = wel_r;
        status[STAT_QE_BIT]  = ctrl_r[CTRL_QE_BIT];
        rd_word = (state_r == ST_RD_BOOT) ? byte_swap(boot_reg_r) : {4{status}};
        bit_pos = 5'd31 - cnt_r[4:0];
    end

    // frame sequencer; a chip enable rise always ends the frame
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state_r       <= ST_IDLE;
            cnt_r         <= 6'd0;
            quad_r        <= 1'b0;
            unlock_seen_r <= 1'b0;
        end
        else if (ce_s)
        begin
            state_r       <= ST_IDLE;
            cnt_r         <= 6'd0;
            unlock_seen_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    state_r <= ST_OPCODE;
                    cnt_r   <= 6'd0;
                    quad_r  <= ctrl_r[CTRL_QUAD_BIT];
                end
                ST_OPCODE:
                begin
                    if (sck_rise)
                    begin
                        if (cnt_nxt == OPCODE_BITS)
                        begin
                            cnt_r <= 6'd0;
                            if (rx_nxt[7:0] == OP_STATUS_READ)
                                state_r <= ST_RD_STAT;
                            else if (wip_r)
                                state_r <= ST_IGNORE;
                            else if (rx_nxt[7:0] == OP_BOOT_REG_READ)
                                state_r <= ST_RD_BOOT;
                            else if (rx_nxt[7:0] == OP_BOOT_REG_WRITE && wel_r)
                                state_r <= ST_WR_DATA;
                            else
                            begin
                                state_r       <= ST_IGNORE;
                                unlock_seen_r <= (rx_nxt[7:0] == OP_WRITE_UNLOCK);
                            end
                        end
                        else
                            cnt_r <= cnt_nxt;
                    end
                end
                ST_RD_BOOT, ST_RD_STAT:
                begin
                    // index wraps at 32 so the word simply repeats
                    if (sck_fall)
                        cnt_r <= {1'b0, cnt_nxt[4:0]};
                end
                ST_WR_DATA:
                begin
                    if (sck_rise && cnt_r <= DATA_BITS)
                        cnt_r <= cnt_nxt;
                end
                ST_IGNORE:
                    cnt_r <= cnt_r;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            rx_r <= 32'h0;
        else if (sck_rise && !ce_s && (state_r == ST_OPCODE || state_r == ST_WR_DATA))
            rx_r <= rx_nxt;
    end

    // write latch, busy flag and the retained register itself
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            wel_r   <= 1'b0;
            wip_r   <= 1'b0;
            timer_r <= 20'h0;
            pend_r  <= 32'h0;
        end
        else if (wip_r)
        begin
            if (timer_r == 20'h0)
            begin
                wip_r      <= 1'b0;
                wel_r      <= 1'b0;
                boot_reg_r <= pend_r;
            end
            else
                timer_r <= timer_r - 20'h1;
        end
        else if (ce_rise && state_r == ST_WR_DATA && cnt_r == DATA_BITS)
        begin
            wip_r   <= 1'b1;
            timer_r <= 20'(WRITE_CYCLES_P - 1);
            pend_r  <= byte_swap(rx_r);
        end
        else if (ce_rise && unlock_seen_r)
            wel_r <= 1'b1;
    end

    // drive changes only after the clock falls, holding for the next rise
    always_ff @(posedge CLK)
    begin
        if (!RESET_N || ce_s || !(state_r == ST_RD_BOOT || state_r == ST_RD_STAT))
        begin
            SPI_IO_OUT  <= 4'h0;
            SPI_IO_OE_N <= 4'hf;
        end
        else if (sck_fall)
        begin
            if (quad_r)
            begin
                SPI_IO_OUT  <= rd_word[bit_pos -: 4];
                SPI_IO_OE_N <= 4'h0;
            end
            else
            begin
                SPI_IO_OUT  <= {2'b00, rd_word[bit_pos], 1'b0};
                SPI_IO_OE_N <= 4'hd;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            ctrl_r    <= CTRL_RESET;
            REG_RDATA <= 32'h0;
        end
        else
        begin
            if (REG_WR && REG_ADDR == REG_CTRL)
                ctrl_r <= REG_WDATA[1:0];
            REG_RDATA <= 32'h0;
            if (REG_RD)
            begin
                case (REG_ADDR)
                    REG_CTRL:   REG_RDATA <= {30'h0, ctrl_r};
                    REG_STATUS: REG_RDATA <= {24'h0, status};
                    REG_BOOT:   REG_RDATA <= boot_reg_r;
                    default:    REG_RDATA <= 32'h0;
                endcase
            end
        end
    end

    // decoded boot settings for the boot read engine
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            rst_done_r       <= 1'b0;
            BOOT_READ_ARMED  <= 1'b0;
            BOOT_START_ADDR  <= '0;
            BOOT_START_DELAY <= '0;
            BOOT_ENABLE      <= 1'b0;
            BOOT_QUAD_SELECT <= 1'b0;
            WRITE_BUSY       <= 1'b0;
        end
        else
        begin
            rst_done_r       <= 1'b1;
            BOOT_START_ADDR  <= boot_reg_r[BOOT_ADDR_LSB +: BOOT_ADDR_W];
            BOOT_START_DELAY <= boot_reg_r[BOOT_DLY_LSB +: BOOT_DLY_W];
            BOOT_ENABLE      <= boot_reg_r[BOOT_EN_BIT];
            BOOT_QUAD_SELECT <= ctrl_r[CTRL_QE_BIT];
            WRITE_BUSY       <= wip_r;
            if (!rst_done_r)
                BOOT_READ_ARMED <= boot_reg_r[BOOT_EN_BIT];
            else if (ce_rise)
                BOOT_READ_ARMED <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_commit;
        ce_rise && state_r == ST_WR_DATA && cnt_r == DATA_BITS && !wip_r;
    endsequence
    sequence s_short_write;
        ce_rise && state_r == ST_WR_DATA && cnt_r != DATA_BITS && !wip_r;
    endsequence

    chk_commit_start: assert property (s_commit |=> wip_r && pend_r == byte_swap($past(rx_r)))
        else $error("write did not start on chip enable rise");
    chk_short_discard: assert property (s_short_write |=> !wip_r && boot_reg_r == $past(boot_reg_r))
        else $error("mis-sized write was not discarded");
    chk_busy_holds: assert property ($rose(wip_r) |-> wip_r[*8])
        else $error("busy flag dropped early");
    chk_latch_cleared: assert property ($fell(wip_r) |-> !wel_r && boot_reg_r == $past(pend_r))
        else $error("latch not cleared at write end");
    chk_latch_needed: assert property ($rose(wip_r) |-> $past(wel_r))
        else $error("write ran without latch");
    chk_read_low_byte: assert property (state_r == ST_RD_BOOT && !ce_s && sck_fall && cnt_r == 6'd0 && !quad_r
        |=> SPI_IO_OUT[1] == boot_reg_r[7] && SPI_IO_OE_N == 4'hd)
        else $error("boot read did not start with low byte msb");
    chk_read_wraps: assert property (state_r == ST_RD_BOOT && !ce_s && sck_fall && cnt_r[4:0] == 5'd31
        |=> ce_s || (state_r == ST_RD_BOOT && cnt_r == 6'd0))
        else $error("boot read did not wrap");
    chk_status_busy: assert property (wip_r && state_r == ST_RD_STAT && !ce_s && sck_fall && !quad_r
        && cnt_r[2:0] == 3'd7 |=> SPI_IO_OUT[1])
        else $error("busy flag not reported");
    chk_quad_lanes: assert property (quad_r && state_r == ST_RD_BOOT && !ce_s && sck_fall && cnt_r == 6'd0
        |=> SPI_IO_OE_N == 4'h0 && SPI_IO_OUT == boot_reg_r[7:4])
        else $error("quad read lanes wrong");
    chk_quad_select: assert property (##1 BOOT_QUAD_SELECT == $past(ctrl_r[CTRL_QE_BIT]))
        else $error("quad select not following enable bit");

endmodule : boot_config_register_access

// ===== verification/spi_host_model.sv
// host side serial controller model for the command link
`timescale 1ns/10ps
module spi_host_model
(
    output logic            ce_n,
    output logic            sck,
    output logic      [3:0] io,
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe_n
);
    logic [3:0] mask;
    logic [3:0] val;
    logic [3:0] junk;
    initial
    begin
        ce_n = 1'b1;
        sck  = 1'b0;
        mask = 4'h0;
        val  = 4'h0;
        junk = 4'h5;
    end
    // released lines keep toggling so a stale bit never passes
    always #32 junk = ~junk;
    always_comb
        for (int i = 0; i < 4; i++)
            io[i] = !dev_oe_n[i] ? dev_out[i] : (mask[i] ? val[i] : junk[i]);
    // sck stands low outside frames; data changes only after a fall
    task automatic frame(input logic [7:0] op, input bit quad, input logic [63:0] wd, input int nw,
                         input int nr, output logic [63:0] rd);
        logic [71:0] sh;
        int          step;
        sh   = {op, wd};
        step = quad ? 4 : 1;
        rd   = '0;
        mask = quad ? 4'hf : 4'h1;
        ce_n = 1'b0;
        for (int i = 0; i < 8 + nw; i += step)
        begin
            val = quad ? sh[71:68] : {3'h0, sh[71]};
            sh  = sh << step;
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
        mask = 4'h0;
        for (int i = 0; i < nr; i += step)
        begin
            #32 sck = 1'b1;
            rd = quad ? {rd[59:0], io} : {rd[62:0], io[1]};
            #32 sck = 1'b0;
        end
        #32 ce_n = 1'b1;
        #160;
    endtask : frame
endmodule : spi_host_model

// ===== verification/tb_boot_config_register_access.sv
// self-checking bench for the boot-configuration register command block
`timescale 1ns/10ps
module tb_boot_config_register_access import boot_cfg_pkg::*;;
    localparam int          WR_P = 400;
    localparam logic [31:0] V1   = 32'hc3a5_1e2b;
    localparam logic [31:0] V2   = 32'h0f1e_2d3d;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ce_n, sck, b_en, armed, qsel, busy;
    logic [3:0]  io, io_out, io_oe_n, b_dly;
    logic [26:0] b_addr;
    logic        ce_d = 1'b1;
    logic        busy_d = 1'b0;
    int          since_ce = 0, busy_run = 0, busy_lat = 0, busy_len = 0;
    int          num_errors = 0, checks = 0, cyc = 0;
    logic [63:0] rd;

    always #2.5 clk = ~clk;

    boot_config_register_access #(.WRITE_CYCLES_P(WR_P)) boot_config_register_access_inst (
        .CLK(clk), .RESET_N(reset_n), .SPI_CE_N(ce_n), .SPI_SCK(sck), .SPI_IO_IN(io),
        .SPI_IO_OUT(io_out), .SPI_IO_OE_N(io_oe_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BOOT_START_ADDR(b_addr),
        .BOOT_START_DELAY(b_dly), .BOOT_ENABLE(b_en), .BOOT_READ_ARMED(armed),
        .BOOT_QUAD_SELECT(qsel), .WRITE_BUSY(busy));
    spi_host_model spi_host_model_inst (.ce_n(ce_n), .sck(sck), .io(io), .dev_out(io_out),
        .dev_oe_n(io_oe_n));

    // measures the delay from chip enable rise to busy and the busy length
    always @(posedge clk)
    begin
        ce_d     <= ce_n;
        busy_d   <= busy;
        since_ce <= (ce_n && !ce_d) ? 0 : since_ce + 1;
        busy_run <= busy ? busy_run + 1 : 0;
        if (busy && !busy_d)
            busy_lat <= since_ce;
        if (!busy && busy_d)
            busy_len <= busy_run;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [31:0] order(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : order

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 check(what, exp, reg_rdata);
    endtask : bus_read

    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic spi_status(input bit q, input logic [7:0] exp, input string what);
        spi_host_model_inst.frame(OP_STATUS_READ, q, 64'h0, 0, 8, rd);
        check(what, exp, rd[7:0]);
    endtask : spi_status

    task automatic write_commit(input logic [31:0] v, input bit q);
        logic [7:0] qe;
        int         n;
        qe = q ? 8'h40 : 8'h00;
        n  = 0;
        spi_host_model_inst.frame(OP_WRITE_UNLOCK, q, 64'h0, 0, 0, rd);
        spi_status(q, qe | 8'h02, "latch set");
        spi_host_model_inst.frame(OP_BOOT_REG_WRITE, q, {order(v), 32'h0}, 32, 0, rd);
        spi_status(q, qe | 8'h03, "busy poll");
        while (busy !== 1'b0 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        check("busy start", 1, busy_lat <= 8);
        check("busy length", 1, busy_len >= WR_P - 1 && busy_len <= WR_P + 1);
        spi_status(q, qe, "busy clear");
        bus_read(REG_BOOT, v, "boot reg");
    endtask : write_commit

    task automatic t_idle;
        bus_read(REG_BOOT, BOOT_REG_RESET, "boot reset");
        bus_read(REG_STATUS, 32'h0, "status reset");
        bus_read(4'hc, 32'h0, "unmapped");
        bus_write(REG_BOOT, 32'hffff_ffff);
        bus_read(REG_BOOT, 32'h0, "boot via port");
        check("idle oe", 4'hf, io_oe_n);
        check("armed off", 0, armed);
    endtask : t_idle

    task automatic t_locked;
        spi_host_model_inst.frame(OP_BOOT_REG_WRITE, 0, {order(V1), 32'h0}, 32, 0, rd);
        check("locked busy", 0, busy);
        bus_read(REG_BOOT, 32'h0, "locked reg");
    endtask : t_locked

    task automatic t_write;
        write_commit(V1, 0);
        check("start addr", V1[31:5], b_addr);
        check("start delay", V1[4:1], b_dly);
        check("enable", V1[0], b_en);
        spi_host_model_inst.frame(OP_BOOT_REG_READ, 0, 64'h0, 0, 64, rd);
        check("boot stream", {order(V1), order(V1)}, rd);
    endtask : t_write

    task automatic t_bad_count;
        spi_host_model_inst.frame(OP_WRITE_UNLOCK, 0, 64'h0, 0, 0, rd);
        spi_host_model_inst.frame(OP_BOOT_REG_WRITE, 0, {order(~V1), 32'h0}, 31, 0, rd);
        spi_host_model_inst.frame(OP_BOOT_REG_WRITE, 0, {order(~V1), 32'h0}, 33, 0, rd);
        check("short busy", 0, busy);
        bus_read(REG_BOOT, V1, "discarded");
        bus_read(REG_STATUS, 32'h2, "latch kept");
    endtask : t_bad_count

    task automatic t_quad;
        bus_write(REG_CTRL, 32'h3);
        bus_read(REG_CTRL, 32'h3, "ctrl");
        check("quad select", 1, qsel);
        write_commit(V2, 1);
        spi_host_model_inst.frame(OP_BOOT_REG_READ, 1, 64'h0, 0, 64, rd);
        check("quad stream", {order(V2), order(V2)}, rd);
        bus_write(REG_CTRL, 32'h0);
        bus_read(REG_STATUS, 32'h0, "qe off");
        check("single select", 0, qsel);
    endtask : t_quad

    task automatic t_armed;
        do_reset();
        check("armed", 1, armed);
        bus_read(REG_BOOT, V2, "kept");
        spi_status(0, 8'h00, "status");
        check("disarm", 0, armed);
    endtask : t_armed

    initial
    begin
        do_reset();
        t_idle();
        t_locked();
        t_write();
        t_bad_count();
        t_quad();
        t_armed();
        test_done();
    end
endmodule : tb_boot_config_register_access
